// file: shared/bank_timing_pkg.sv
// Shared constants and types for the per-bank precharge timing tracker.
package bank_timing_pkg;

    // Array organisation and burst shape.
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int BURST_LENGTH = 8;
    localparam int PREFETCH_WORDS = 8;
    localparam int RTP_FLOOR_CLK = 4;
    localparam int CNT_W = 8;

    // Analog times in picoseconds, with the command clock period they are rounded against.
    localparam int CMD_CLK_PERIOD_PS = 125000;
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam int READ_TO_PRECHARGE_TIME_PS = 7500;
    localparam int SINGLE_BANK_PRECHARGE_TIME_PS = 18000;
    localparam int ALL_BANK_PRECHARGE_TIME_PS = 21000;
    localparam int ROW_CYCLE_TIME_PS = 60000;

    // Least times round up to whole command clocks and never fall below one clock.
    function automatic int round_up(input int t_ps);
        int c;
        c = (t_ps + CMD_CLK_PERIOD_PS - 1) / CMD_CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WR_CLK = round_up(WRITE_RECOVERY_TIME_PS);
    localparam int RTP_CLK = round_up(READ_TO_PRECHARGE_TIME_PS);
    localparam int RPPB_CLK = round_up(SINGLE_BANK_PRECHARGE_TIME_PS);
    localparam int RPAB_CLK = round_up(ALL_BANK_PRECHARGE_TIME_PS);
    localparam int RC_CLK = round_up(ROW_CYCLE_TIME_PS);
    // Half burst plus the larger of the floor and the rounded read-to-precharge time, minus the floor.
    localparam int RD_TO_PRE_CLK = BURST_LENGTH / 2 + ((RTP_CLK > RTP_FLOOR_CLK) ? RTP_CLK : RTP_FLOOR_CLK)
                                   - RTP_FLOOR_CLK;

    // Counter load values at counter width.
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CLK);
    localparam logic [CNT_W-1:0] RD_TO_PRE_CNT = CNT_W'(RD_TO_PRE_CLK);
    localparam logic [CNT_W-1:0] RPPB_CNT = CNT_W'(RPPB_CLK);
    localparam logic [CNT_W-1:0] RPAB_CNT = CNT_W'(RPAB_CLK);
    localparam logic [CNT_W-1:0] RC_CNT = CNT_W'(RC_CLK);
    localparam logic [2:0] WORD_LAST = 3'(PREFETCH_WORDS - 1);
    localparam logic [2:0] WORD_ZERO = 3'h0;
    localparam logic [2:0] WORD_ONE = 3'h1;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE} cmd_code_t;

    typedef enum logic [2:0] {BK_IDLE, BK_ACTIVE, BK_WR_BURST, BK_WR_RECOV, BK_RD_AP, BK_PRECHARGE} bank_state_t;

endpackage

// file: shared/bank_ctl_if.sv
// Command strobes into one bank tracker and its status back out.
`timescale 1ns/1ps
interface bank_ctl_if;
    logic act;
    logic rd;
    logic wr;
    logic pre;
    logic ap;
    logic pre_all;
    logic grp_done;
    logic is_open;
    logic is_precharging;
    logic wr_busy;
    logic rd_hold;
    logic violation;

    modport ctl (output act, output rd, output wr, output pre, output ap, output pre_all, output grp_done,
                 input is_open, input is_precharging, input wr_busy, input rd_hold, input violation);
    modport bank (input act, input rd, input wr, input pre, input ap, input pre_all, input grp_done,
                  output is_open, output is_precharging, output wr_busy, output rd_hold, output violation);
endinterface

// file: hdl/bank_tracker.sv
// One bank's open state and its recovery, read hold and precharge countdowns.
`timescale 1ns/1ps
module bank_tracker (
    input wire logic clk,
    input wire logic rst_n,
    bank_ctl_if.bank bif
);
    bank_timing_pkg::bank_state_t state_r, state_nxt;
    logic [bank_timing_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [bank_timing_pkg::CNT_W-1:0] rd_hold_r, rd_hold_nxt;
    logic [bank_timing_pkg::CNT_W-1:0] rc_r, rc_nxt;
    logic ap_r, ap_nxt;
    logic viol_r;

    // Status decode of the present state.
    wire logic st_active = (state_r == bank_timing_pkg::BK_ACTIVE);
    wire logic st_wr = (state_r == bank_timing_pkg::BK_WR_BURST) || (state_r == bank_timing_pkg::BK_WR_RECOV);
    wire logic cnt_last = (cnt_r == bank_timing_pkg::CNT_ONE);
    wire logic hold_on = (rd_hold_r != bank_timing_pkg::CNT_ZERO);
    wire logic act_ok = (state_r == bank_timing_pkg::BK_IDLE) && (rc_r == bank_timing_pkg::CNT_ZERO);
    wire logic [bank_timing_pkg::CNT_W-1:0] rp_load = bif.pre_all ? bank_timing_pkg::RPAB_CNT
                                                                   : bank_timing_pkg::RPPB_CNT;
    // Early precharge, a premature activate, or a column access to a closed bank is flagged.
    wire logic pre_bad = bif.pre && (st_wr || hold_on);
    wire logic act_bad = bif.act && !act_ok;
    wire logic rw_bad = (bif.rd || bif.wr) && !(st_active || st_wr);
    wire logic any_bad = pre_bad || act_bad || rw_bad;

    assign bif.is_open = (state_r != bank_timing_pkg::BK_IDLE) && (state_r != bank_timing_pkg::BK_PRECHARGE);
    assign bif.is_precharging = (state_r == bank_timing_pkg::BK_PRECHARGE);
    assign bif.wr_busy = st_wr;
    assign bif.rd_hold = hold_on;
    assign bif.violation = viol_r;

    // Next state; a precharge always wins so the bank cannot be left half open.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r == bank_timing_pkg::CNT_ZERO) ? cnt_r : cnt_r - bank_timing_pkg::CNT_ONE;
        ap_nxt = ap_r;
        case (state_r)
            bank_timing_pkg::BK_IDLE: begin
                if (bif.act && act_ok) begin
                    state_nxt = bank_timing_pkg::BK_ACTIVE;
                end
            end
            bank_timing_pkg::BK_ACTIVE: begin
                if (bif.pre) begin
                    state_nxt = bank_timing_pkg::BK_PRECHARGE;
                    cnt_nxt = rp_load;
                end else if (bif.rd && bif.ap) begin
                    state_nxt = bank_timing_pkg::BK_RD_AP;
                    cnt_nxt = bank_timing_pkg::RD_TO_PRE_CNT;
                end else if (bif.wr) begin
                    state_nxt = bank_timing_pkg::BK_WR_BURST;
                    ap_nxt = bif.ap;
                end
            end
            bank_timing_pkg::BK_WR_BURST, bank_timing_pkg::BK_WR_RECOV: begin
                if (bif.pre) begin
                    state_nxt = bank_timing_pkg::BK_PRECHARGE;
                    cnt_nxt = rp_load;
                end else if (bif.wr) begin
                    state_nxt = bank_timing_pkg::BK_WR_BURST;
                    ap_nxt = bif.ap;
                end else if (bif.grp_done && state_r == bank_timing_pkg::BK_WR_BURST) begin
                    state_nxt = bank_timing_pkg::BK_WR_RECOV;
                    cnt_nxt = bank_timing_pkg::WR_CNT;
                end else if (cnt_last && state_r == bank_timing_pkg::BK_WR_RECOV) begin
                    state_nxt = ap_r ? bank_timing_pkg::BK_PRECHARGE : bank_timing_pkg::BK_ACTIVE;
                    cnt_nxt = bank_timing_pkg::RPPB_CNT;
                end
            end
            bank_timing_pkg::BK_RD_AP: begin
                if (bif.pre || cnt_last) begin
                    state_nxt = bank_timing_pkg::BK_PRECHARGE;
                    cnt_nxt = bif.pre ? rp_load : bank_timing_pkg::RPPB_CNT;
                end
            end
            bank_timing_pkg::BK_PRECHARGE: begin
                if (cnt_last) begin
                    state_nxt = bank_timing_pkg::BK_IDLE;
                end
            end
            default: begin
                state_nxt = bank_timing_pkg::BK_IDLE;
            end
        endcase
    end

    // The read hold and row cycle timers run beside the state, independent of other banks.
    assign rd_hold_nxt = (bif.rd && st_active) ? bank_timing_pkg::RD_TO_PRE_CNT
                       : hold_on ? rd_hold_r - bank_timing_pkg::CNT_ONE : rd_hold_r;
    assign rc_nxt = (bif.act && act_ok) ? bank_timing_pkg::RC_CNT
                  : (rc_r != bank_timing_pkg::CNT_ZERO) ? rc_r - bank_timing_pkg::CNT_ONE : rc_r;

    // State and timer registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= bank_timing_pkg::BK_IDLE;
            cnt_r <= bank_timing_pkg::CNT_ZERO;
            rd_hold_r <= bank_timing_pkg::CNT_ZERO;
            rc_r <= bank_timing_pkg::CNT_ZERO;
            ap_r <= 1'b0;
            viol_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rd_hold_r <= rd_hold_nxt;
            rc_r <= rc_nxt;
            ap_r <= ap_nxt;
            viol_r <= any_bad;
        end
    end

    localparam int RD_AP_D = bank_timing_pkg::RD_TO_PRE_CLK + 1;
    localparam int WR_AP_D = bank_timing_pkg::WR_CLK + 1;
    localparam int RPPB_D = bank_timing_pkg::RPPB_CLK;
    localparam int RPAB_D = bank_timing_pkg::RPAB_CLK;
    // The antecedent of the write check already spans two cycles past the group edge.
    localparam int WR_AP_TAIL = WR_AP_D - 2;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_read_ap_start: assert property (st_active && bif.rd && bif.ap && !bif.pre |->
        ##RD_AP_D bif.is_precharging && $rose(bif.is_precharging)) else $error("read auto precharge late or early");
    chk_write_ap_start: assert property ($fell(bif.wr_busy) && $past(ap_r) && bif.is_precharging |->
        $past(state_r == bank_timing_pkg::BK_WR_RECOV, 1)) else $error("write auto precharge from wrong state");
    chk_write_ap_delay: assert property (state_r == bank_timing_pkg::BK_WR_BURST && bif.grp_done && ap_r
        && !bif.pre && !bif.wr ##1 (!bif.pre && !bif.wr)[*2] |-> ##WR_AP_TAIL bif.is_precharging)
        else $error("write auto precharge not at recovery end");
    chk_plain_stays_open: assert property (st_active && bif.rd && !bif.ap && !bif.pre |=> st_active)
        else $error("plain read closed the bank");
    chk_single_pre_time: assert property ($rose(bif.is_precharging) && cnt_r == bank_timing_pkg::RPPB_CNT
        |-> ##RPPB_D (state_r == bank_timing_pkg::BK_IDLE)) else $error("single bank precharge length wrong");
    chk_all_pre_time: assert property (st_active && bif.pre && bif.pre_all |=> bif.is_precharging
        ##RPAB_D !bif.is_precharging) else $error("all bank precharge length wrong");
    chk_early_pre_flag: assert property (bif.pre && st_wr |=> viol_r) else $error("early precharge not flagged");
    chk_act_open_flag: assert property (bif.act && bif.is_open |=> viol_r && bif.is_open)
        else $error("activate on open bank not flagged");
    chk_read_hold: assert property (bif.rd && st_active |=> bif.rd_hold [*4])
        else $error("read to precharge hold too short");

    cov_read_ap: cover property (st_active && bif.rd && bif.ap ##RD_AP_D bif.is_precharging);
    cov_write_ap: cover property (state_r == bank_timing_pkg::BK_WR_RECOV && ap_r ##1 bif.is_precharging);
    cov_all_pre: cover property (st_active && bif.pre && bif.pre_all);

endmodule // bank_tracker

// file: hdl/bank_precharge_timing.sv
// Top of the per-bank precharge timing tracker with its command clock and core clock domains.
//
// Functional notes
// - Array write and recovery count start only once eight data words are latched.
// - Access with auto precharge flag low leaves the bank open after the burst.
// - Access with auto precharge flag high closes the bank at the earliest moment.
// - Read auto precharge starts at max of half burst, half burst minus four plus rtp.
// - Write auto precharge starts write recovery cycles after the burst completes.
// - Precharge names one bank by three bits, or all banks when selected.
`timescale 1ns/1ps
module bank_precharge_timing (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cmd_clk,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_bank,
    input wire logic auto_precharge_flag,
    input wire logic all_bank_select,
    input wire logic wr_word_valid,
    output logic [7:0] bank_open,
    output logic [7:0] bank_precharging,
    output logic timing_violation
);
    localparam int NB = bank_timing_pkg::NUM_BANKS;

    // Link domain reset: the core reset is brought over and used synchronously on the command clock.
    logic link_rst_s1_r;
    logic link_rst_n_r;

    always_ff @(posedge cmd_clk) begin
        link_rst_s1_r <= resetn;
        link_rst_n_r <= link_rst_s1_r;
    end

    // Pin capture, two flops deep; the first stage feeds only the second.
    logic valid_s1_r, valid_s2_r;
    logic [2:0] code_s1_r, code_s2_r;
    logic [2:0] bank_s1_r, bank_s2_r;
    logic ap_s1_r, ap_s2_r;
    logic all_s1_r, all_s2_r;
    logic word_s1_r, word_s2_r;

    always_ff @(posedge cmd_clk) begin
        if (!link_rst_n_r) begin
            valid_s1_r <= 1'b0;
            valid_s2_r <= 1'b0;
            word_s1_r <= 1'b0;
            word_s2_r <= 1'b0;
        end else begin
            valid_s1_r <= cmd_valid;
            valid_s2_r <= valid_s1_r;
            word_s1_r <= wr_word_valid;
            word_s2_r <= word_s1_r;
        end
    end

    // Command fields only matter when qualified by the valid bit, so they need no reset.
    always_ff @(posedge cmd_clk) begin
        code_s1_r <= cmd_code;
        code_s2_r <= code_s1_r;
        bank_s1_r <= cmd_bank;
        bank_s2_r <= bank_s1_r;
        ap_s1_r <= auto_precharge_flag;
        ap_s2_r <= ap_s1_r;
        all_s1_r <= all_bank_select;
        all_s2_r <= all_s1_r;
    end

    // Command decode from the captured fields.
    wire logic is_act = valid_s2_r && (code_s2_r == bank_timing_pkg::CMD_ACTIVATE);
    wire logic is_rd = valid_s2_r && (code_s2_r == bank_timing_pkg::CMD_READ);
    wire logic is_wr = valid_s2_r && (code_s2_r == bank_timing_pkg::CMD_WRITE);
    wire logic is_pre = valid_s2_r && (code_s2_r == bank_timing_pkg::CMD_PRECHARGE);

    // Write data word counter and the bank that owns the burst in flight.
    // Only one write burst is tracked at a time; the latest write command takes the counter over.
    logic [2:0] word_cnt_r, word_cnt_nxt;
    logic [2:0] wr_bank_r, wr_bank_nxt;

    wire logic grp_done = word_s2_r && (word_cnt_r == bank_timing_pkg::WORD_LAST);

    assign word_cnt_nxt = is_wr ? bank_timing_pkg::WORD_ZERO
                        : word_s2_r ? word_cnt_r + bank_timing_pkg::WORD_ONE : word_cnt_r;
    assign wr_bank_nxt = is_wr ? bank_s2_r : wr_bank_r;

    always_ff @(posedge cmd_clk) begin
        if (!link_rst_n_r) begin
            word_cnt_r <= bank_timing_pkg::WORD_ZERO;
            wr_bank_r <= 3'h0;
        end else begin
            word_cnt_r <= word_cnt_nxt;
            wr_bank_r <= wr_bank_nxt;
        end
    end

    // One tracker per bank; the all-bank select ignores the bank bits for precharge.
    bank_ctl_if bif [NB] ();
    logic [NB-1:0] open_vec;
    logic [NB-1:0] prech_vec;
    logic [NB-1:0] viol_vec;

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_bank
            wire logic hit = (bank_s2_r == 3'(gi));
            wire logic wr_hit = (wr_bank_r == 3'(gi));

            assign bif[gi].act = is_act && hit;
            assign bif[gi].rd = is_rd && hit;
            assign bif[gi].wr = is_wr && hit;
            assign bif[gi].pre = is_pre && (all_s2_r || hit);
            assign bif[gi].ap = ap_s2_r;
            assign bif[gi].pre_all = all_s2_r;
            assign bif[gi].grp_done = grp_done && wr_hit;
            assign open_vec[gi] = bif[gi].is_open;
            assign prech_vec[gi] = bif[gi].is_precharging;
            assign viol_vec[gi] = bif[gi].violation;

            bank_tracker u_bank (
                .clk(cmd_clk),
                .rst_n(link_rst_n_r),
                .bif(bif[gi])
            );
        end
    endgenerate

    // Status is registered in the link domain so the crossing samples glitch-free levels.
    logic [NB-1:0] open_link_r;
    logic [NB-1:0] prech_link_r;
    logic viol_tog_r;

    always_ff @(posedge cmd_clk) begin
        if (!link_rst_n_r) begin
            open_link_r <= '0;
            prech_link_r <= '0;
            viol_tog_r <= 1'b0;
        end else begin
            open_link_r <= open_vec;
            prech_link_r <= prech_vec;
            viol_tog_r <= viol_tog_r ^ (|viol_vec);
        end
    end

    // Core domain: each status bit is an independent level, so per-bit two-flop sync is enough.
    // Bits of different banks may arrive one core clock apart; that skew is harmless for levels.
    logic [NB-1:0] open_s1_r, open_s2_r;
    logic [NB-1:0] prech_s1_r, prech_s2_r;
    logic tog_s1_r, tog_s2_r, tog_s3_r;
    logic viol_pulse_r;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            open_s1_r <= '0;
            open_s2_r <= '0;
            prech_s1_r <= '0;
            prech_s2_r <= '0;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            viol_pulse_r <= 1'b0;
        end else begin
            open_s1_r <= open_link_r;
            open_s2_r <= open_s1_r;
            prech_s1_r <= prech_link_r;
            prech_s2_r <= prech_s1_r;
            tog_s1_r <= viol_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            viol_pulse_r <= tog_s2_r ^ tog_s3_r;
        end
    end

    // Outputs come straight from the last synchroniser or pulse flops.
    assign bank_open = open_s2_r;
    assign bank_precharging = prech_s2_r;
    assign timing_violation = viol_pulse_r;

    // Checks in the command clock domain.
    chk_group_done_count: assert property (@(posedge cmd_clk) disable iff (!link_rst_n_r)
        grp_done |-> $past(word_cnt_r) == 3'h6 || $past(is_wr)) else $error("group completed off boundary");
    chk_pre_all_hits: assert property (@(posedge cmd_clk) disable iff (!link_rst_n_r)
        is_pre && all_s2_r |-> bif[0].pre && bif[NB-1].pre) else $error("all bank precharge missed a bank");
    chk_viol_toggle: assert property (@(posedge cmd_clk) disable iff (!link_rst_n_r)
        (|viol_vec) |=> viol_tog_r != $past(viol_tog_r)) else $error("violation event lost");

    // Checks in the core clock domain.
    chk_viol_pulse_one: assert property (@(posedge core_clk) disable iff (!resetn)
        viol_pulse_r && !(tog_s2_r ^ tog_s3_r) |=> !viol_pulse_r) else $error("violation pulse stretched");

    cov_viol_seen: cover property (@(posedge core_clk) disable iff (!resetn) viol_pulse_r);
    cov_two_banks_open: cover property (@(posedge core_clk) disable iff (!resetn) $countones(open_s2_r) > 1);

endmodule // bank_precharge_timing

// file: verif/ctl_model.sv
// Memory controller model that drives commands and write data words on the command clock.
`timescale 1ns/1ps
module ctl_model (
    input wire logic cmd_clk,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [2:0] cmd_bank,
    output logic auto_precharge_flag,
    output logic all_bank_select,
    output logic wr_word_valid
);
    // Pins start quiet so that no command is seen while reset is applied.
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_bank = 3'h0;
        auto_precharge_flag = 1'b0;
        all_bank_select = 1'b0;
        wr_word_valid = 1'b0;
    end
    // One command for one clock; the qualifiers then flip, so a stale value can never pass for a command.
    task automatic issue(input bank_timing_pkg::cmd_code_t code, input logic [2:0] bank, input logic ap,
                         input logic ab);
        @(posedge cmd_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_bank = bank;
        auto_precharge_flag = ap;
        all_bank_select = ab;
        @(posedge cmd_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~code;
        cmd_bank = ~bank;
        auto_precharge_flag = ~ap;
        all_bank_select = ~ab;
    endtask
    // Write data words, one a clock; only the eighth word after the write command ends the burst.
    task automatic words(input int n);
        repeat (n) begin
            @(posedge cmd_clk);
            #1;
            wr_word_valid = 1'b1;
        end
        @(posedge cmd_clk);
        #1;
        wr_word_valid = 1'b0;
    endtask
endmodule // ctl_model

// file: verif/testbench.sv
// Self-checking bench: a controller model drives the link, bank state is judged at the core outputs.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t got %0h expected %0h", $time, g, e); end end
module testbench;
    logic core_clk, cmd_clk, resetn, cmd_valid, auto_precharge_flag, all_bank_select, wr_word_valid, timing_violation;
    logic [2:0] cmd_code, cmd_bank;
    logic [7:0] bank_open, bank_precharging;
    int n_mismatch = 0, checked = 0, n_viol = 0, cycles = 0;
    bank_precharge_timing u_bank_precharge_timing (.core_clk(core_clk), .resetn(resetn), .cmd_clk(cmd_clk),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .auto_precharge_flag(auto_precharge_flag),
        .all_bank_select(all_bank_select), .wr_word_valid(wr_word_valid), .bank_open(bank_open),
        .bank_precharging(bank_precharging), .timing_violation(timing_violation));
    ctl_model u_ctl_model (.cmd_clk(cmd_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .auto_precharge_flag(auto_precharge_flag), .all_bank_select(all_bank_select), .wr_word_valid(wr_word_valid));
    // Core clock at 100 ns.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Link clock at 125 ns, offset so its edges drift against the core clock.
    initial begin
        cmd_clk = 1'b0;
        #37;
        forever #62.5 cmd_clk = ~cmd_clk;
    end
    // Violation pulses last one core cycle, so they are counted here; a hang ends the run.
    always @(posedge core_clk) begin
        cycles++;
        if (timing_violation === 1'b1) n_viol++;
        if (cycles == 6000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Outputs cross two flops, so they are polled for a bounded number of core cycles.
    task automatic settle(input logic [7:0] op, input logic [7:0] pr);
        for (int i = 0; i < 8 && (bank_open !== op || bank_precharging !== pr); i++) @(posedge core_clk) #5;
        `CHK(bank_open, op)
        `CHK(bank_precharging, pr)
    endtask
    task automatic viol(input int exp);
        repeat (12) @(posedge core_clk);
        #5;
        `CHK(n_viol, exp)
    endtask
    task automatic t_read();
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h3, 1'b0, 1'b0);
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h5, 1'b0, 1'b0);
        u_ctl_model.issue(bank_timing_pkg::CMD_READ, 3'h3, 1'b0, 1'b0);
        repeat (8) @(posedge cmd_clk);
        settle(8'h28, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_PRECHARGE, 3'h3, 1'b0, 1'b0);
        settle(8'h20, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_PRECHARGE, 3'h3, 1'b0, 1'b1);
        settle(8'h00, 8'h00);
        viol(0);
        $display("test read done");
    endtask
    task automatic t_read_ap();
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h3, 1'b0, 1'b0);
        settle(8'h08, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_READ, 3'h3, 1'b1, 1'b0);
        repeat (5) @(posedge cmd_clk);
        #10;
        `CHK(bank_precharging, 8'h00)
        settle(8'h00, 8'h08);
        settle(8'h00, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h3, 1'b0, 1'b0);
        settle(8'h08, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_PRECHARGE, 3'h3, 1'b0, 1'b0);
        settle(8'h00, 8'h00);
        viol(0);
        $display("test read_ap done");
    endtask
    task automatic t_write();
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h2, 1'b0, 1'b0);
        u_ctl_model.issue(bank_timing_pkg::CMD_WRITE, 3'h2, 1'b0, 1'b0);
        u_ctl_model.words(8);
        repeat (4) @(posedge cmd_clk);
        settle(8'h04, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_WRITE, 3'h2, 1'b1, 1'b0);
        u_ctl_model.words(7);
        repeat (6) @(posedge cmd_clk);
        settle(8'h04, 8'h00);
        u_ctl_model.issue(bank_timing_pkg::CMD_WRITE, 3'h2, 1'b1, 1'b0);
        u_ctl_model.words(8);
        settle(8'h00, 8'h04);
        settle(8'h00, 8'h00);
        viol(0);
        $display("test write done");
    endtask
    task automatic t_refuse();
        u_ctl_model.issue(bank_timing_pkg::CMD_READ, 3'h6, 1'b0, 1'b0);
        viol(1);
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h6, 1'b0, 1'b0);
        u_ctl_model.issue(bank_timing_pkg::CMD_ACTIVATE, 3'h6, 1'b0, 1'b0);
        viol(2);
        u_ctl_model.issue(bank_timing_pkg::CMD_READ, 3'h6, 1'b0, 1'b0);
        u_ctl_model.issue(bank_timing_pkg::CMD_PRECHARGE, 3'h6, 1'b0, 1'b0);
        settle(8'h00, 8'h00);
        viol(3);
        u_ctl_model.issue(bank_timing_pkg::CMD_PRECHARGE, 3'h6, 1'b0, 1'b0);
        viol(3);
        $display("test refuse done");
    endtask
    initial begin
        resetn = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        repeat (6) @(posedge cmd_clk);
        settle(8'h00, 8'h00);
        t_read();
        t_read_ap();
        t_write();
        t_refuse();
        conclude();
    end
endmodule // testbench
